// *** ifs_defines.vh ***
// Constants for the internal oscillator frequency select and clock switch block
`ifndef IFS_DEFINES_VH
`define IFS_DEFINES_VH
// Register byte addresses
`define IFS_ADDR_CTRL        8'h00
`define IFS_ADDR_STAT        8'h04
// Control register field positions
`define IFS_CTRL_CONFIG_PLL_ENABLE_BIT   7
`define IFS_CTRL_FSEL_HI     6
`define IFS_CTRL_FSEL_LO     3
`define IFS_CTRL_SCS_HI      1
`define IFS_CTRL_SCS_LO      0
// Reset values
`define IFS_FSEL_RESET       4'h7
`define IFS_SCS_RESET        2'h0
// Status register field positions
`define IFS_STAT_PLL_READY_FLAG_BIT    6
`define IFS_STAT_CFG_BIT     5
`define IFS_STAT_HF_BIT      4
`define IFS_STAT_MF_BIT      2
`define IFS_STAT_LF_BIT      1
// Source codes
`define IFS_SRC_HF           2'h0
`define IFS_SRC_MF           2'h1
`define IFS_SRC_LF           2'h2
// Times in ns and their cycle counts at 125 MHz (8 ns), rounded up
`define IFS_CLK_NS           8
`define IFS_STARTUP_NS       2000
`define IFS_STARTUP_CYC      ((`IFS_STARTUP_NS + `IFS_CLK_NS - 1) / `IFS_CLK_NS)
`define IFS_LOCK_NS          2000000
`define IFS_LOCK_CYC         ((`IFS_LOCK_NS + `IFS_CLK_NS - 1) / `IFS_CLK_NS)
`define IFS_WARM_CYC         250
`endif

// *** ifs_clock_switch.v ***
// Internal oscillator frequency select, source select and glitch-free switch
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "ifs_defines.vh"

// Behaviour
// - Codes 1111..1011 give 16..1 MHz high osc
// - Reset loads frequency select with 0111
// - Codes 1010,1001,1000,0011 duplicate from high osc
// - Codes 0110,0101,0100 from medium postscaler
// - 0010 medium 31.25k; 000x low osc
// - 16 MHz halved, 8 MHz direct into PLL
// - 32 MHz needs cfg 00, scs 00, 1111/1110, enable
// - Config PLL enable forces PLL, ignores soft bit
// - Otherwise soft bit turns PLL on/off
// - No PLL while system clock select is 1x
// - Scs 00 config source, 1x/01 internal block
// - Reset clears system clock select
// - Start osc, wait fall, hold low, wait rise
// - Same oscillator source needs no start-up delay
// - Status shows oscillators running after switch
// - Wake from sleep needs warm-up delay
// - Control bits: pll 7, fsel 6:3, scs 1:0
// - Pll ready flag read-only in status
// - Config select 00 makes internal block default
module ifs_clock_switch #(
   parameter LOCK_CYC = `IFS_LOCK_CYC     // PLL lock wait in cycles
) (
   input  wire        CLK,
   input  wire        RST,
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [7:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O,
   input  wire [1:0]  CFG_OSC_SEL,        // Configuration oscillator select
   input  wire        CFG_PLL_ENABLE,     // Configuration PLL enable
   input  wire        SLEEP,              // Device asleep
   input  wire        HF_OSC_CLK,         // 16 MHz high-freq oscillator (pin)
   input  wire        MF_OSC_CLK,         // 500 kHz medium oscillator (pin)
   input  wire        LF_OSC_CLK,         // 31 kHz low oscillator (pin)
   input  wire        EXT_CLK,            // External clock input (pin)
   output reg         HF_OSC_EN,          // High osc enable
   output reg         MF_OSC_EN,          // Medium osc enable
   output reg         LF_OSC_EN,          // Low osc enable
   output reg         PLL_ACTIVE,         // 4x PLL path on the system clock
   output reg  [3:0]  FREQ_SEL,           // Effective postscaler code
   output reg  [1:0]  SOURCE,             // Effective oscillator source
   output reg         USE_CONFIG_SRC,     // Config-defined source selected
   output reg         SYS_CLK             // Gated system clock
);

   ////////////////////////////////////////////////////////////////////////
   // State codes, one-hot
   localparam ST_IDLE  = 5'b00001;        // Stable running
   localparam ST_START = 5'b00010;        // Oscillator start-up delay
   localparam ST_FALL  = 5'b00100;        // Wait old clock falling edge
   localparam ST_RISE  = 5'b01000;        // Held low, wait new rising edge
   localparam ST_WARM  = 5'b10000;        // Wake warm-up delay

   // Counter end points, cut to the 21-bit counter width on purpose
   localparam integer START_I   = `IFS_STARTUP_CYC - 1;   // Last start-up count
   localparam integer WARM_I    = `IFS_WARM_CYC - 1;      // Last warm-up count
   localparam integer LOCK_I    = LOCK_CYC - 1;           // Last lock count
   localparam [20:0]  START_LIM = START_I[20:0];          // Start-up end
   localparam [20:0]  WARM_LIM  = WARM_I[20:0];           // Warm-up end
   localparam [20:0]  LOCK_LIM  = LOCK_I[20:0];           // Lock end

   // Map a frequency code to its oscillator source
   function [1:0] src_of;
      input [3:0] code;
      begin
         if (code[3] || code == 4'h3)
            src_of = `IFS_SRC_HF;
         else if (code[3:1] == 3'h0)
            src_of = `IFS_SRC_LF;
         else
            src_of = `IFS_SRC_MF;
      end
   endfunction

   // Select one clock level by source
   function clk_of;
      input [1:0] s;
      input       h;
      input       m;
      input       l;
      begin
         if (s == `IFS_SRC_HF)
            clk_of = h;
         else if (s == `IFS_SRC_MF)
            clk_of = m;
         else
            clk_of = l;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and state
   reg         soft_pll_enable;            // Control bit 7
   reg  [3:0]  internal_freq_select;       // Control bits 6:3
   reg  [1:0]  system_clock_select;        // Control bits 1:0
   reg  [4:0]  state;                      // Switch state
   reg  [20:0] dly;                        // Delay counter
   reg  [20:0] lock_cnt;                   // PLL lock counter
   reg         pll_ready_flag;             // PLL ready
   reg  [3:0]  hf_s, mf_s, lf_s, ex_s;     // Two-stage synchronisers
   reg         old_clk_d, new_clk_d;       // Edge history
   reg         sleep_d;                    // Sleep history
   reg  [1:0]  tgt_src;                    // Source being switched to
   reg  [3:0]  tgt_code;                   // Code being switched to
   wire        hf_c = hf_s[1];
   wire        mf_c = mf_s[1];
   wire        lf_c = lf_s[1];
   wire        ex_c = ex_s[1];
   wire        wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Writes land at the edge that sees ack high, while the master still
   // holds address and data; read data is launched one edge earlier
   wire        wr_ctrl = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0] &
                         (WB_ADR_I == `IFS_ADDR_CTRL);
   wire        cfg_int = (CFG_OSC_SEL == 2'h0);
   wire        use_int = system_clock_select != 2'h0;
   wire        pll_on  = CFG_PLL_ENABLE | soft_pll_enable;
   // Lock only counts once the 8/16 MHz setting has really taken over;
   // a pending switch from a slow code must finish first
   wire        pll_req = cfg_int & ~use_int & pll_on &
                         (internal_freq_select[3:1] == 3'h7) &
                         (FREQ_SEL[3:1] == 3'h7);
   wire [1:0]  want_src = src_of(internal_freq_select);
   wire        cur_clk = clk_of(SOURCE, hf_c, mf_c, lf_c);
   wire        new_clk = clk_of(tgt_src, hf_c, mf_c, lf_c);
   wire        new_on  = (tgt_src == `IFS_SRC_HF) ? HF_OSC_EN :
                         (tgt_src == `IFS_SRC_MF) ? MF_OSC_EN : LF_OSC_EN;

   ////////////////////////////////////////////////////////////////////////
   // Pin clock synchronisers
   // Only the second stage is read; upper bits stay zero
   // Pin clocks must run below half the bus clock to be seen
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         hf_s <= 4'h0;
         mf_s <= 4'h0;
         lf_s <= 4'h0;
         ex_s <= 4'h0;
      end else begin
         hf_s <= {2'h0, hf_s[0], HF_OSC_CLK};
         mf_s <= {2'h0, mf_s[0], MF_OSC_CLK};
         lf_s <= {2'h0, lf_s[0], LF_OSC_CLK};
         ex_s <= {2'h0, ex_s[0], EXT_CLK};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register and Wishbone answer
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         soft_pll_enable      <= 1'b0;
         internal_freq_select <= `IFS_FSEL_RESET;
         system_clock_select  <= `IFS_SCS_RESET;
         WB_ACK_O             <= 1'b0;
         WB_DAT_O             <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= wb_req;
         if (wr_ctrl) begin
            soft_pll_enable      <= WB_DAT_I[`IFS_CTRL_CONFIG_PLL_ENABLE_BIT];
            internal_freq_select <= WB_DAT_I[`IFS_CTRL_FSEL_HI:`IFS_CTRL_FSEL_LO];
            system_clock_select  <= WB_DAT_I[`IFS_CTRL_SCS_HI:`IFS_CTRL_SCS_LO];
         end
         // Read data; control bit 2, status bits 7, 3 and 0, and upper bits read zero
         if (wb_req && WB_ADR_I == `IFS_ADDR_CTRL)
            WB_DAT_O <= {24'h00_0000, soft_pll_enable, internal_freq_select,
                         1'b0, system_clock_select};
         else if (wb_req && WB_ADR_I == `IFS_ADDR_STAT)
            WB_DAT_O <= {24'h00_0000, 1'b0, pll_ready_flag, USE_CONFIG_SRC,
                         HF_OSC_EN & (state == ST_IDLE), 1'b0,
                         MF_OSC_EN & (state == ST_IDLE),
                         LF_OSC_EN & (state == ST_IDLE), 1'b0};
         else
            WB_DAT_O <= 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // PLL lock counter and ready flag
   // Any break in the request restarts the lock wait from zero,
   // so the ready flag never reports a half-locked loop
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         lock_cnt       <= 21'h00_0000;
         pll_ready_flag <= 1'b0;
         PLL_ACTIVE     <= 1'b0;
      end else if (!pll_req || SLEEP) begin
         lock_cnt       <= 21'h00_0000;
         pll_ready_flag <= 1'b0;
         PLL_ACTIVE     <= 1'b0;
      end else if (lock_cnt >= LOCK_LIM) begin
         pll_ready_flag <= 1'b1;
         PLL_ACTIVE     <= 1'b1;
      end else begin
         lock_cnt <= lock_cnt + 21'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch sequencer
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         state     <= ST_IDLE;
         dly       <= 21'h00_0000;
         SOURCE    <= `IFS_SRC_MF;
         FREQ_SEL  <= `IFS_FSEL_RESET;
         tgt_src   <= `IFS_SRC_MF;
         tgt_code  <= `IFS_FSEL_RESET;
         HF_OSC_EN <= 1'b0;
         MF_OSC_EN <= 1'b1;
         LF_OSC_EN <= 1'b0;
         old_clk_d <= 1'b0;
         new_clk_d <= 1'b0;
         sleep_d   <= 1'b0;
      end else begin
         old_clk_d <= cur_clk;
         new_clk_d <= new_clk;
         sleep_d   <= SLEEP;
         case (state)
            ST_IDLE: begin
               // Wake has priority; a code change waits for the
               // warm-up to finish and is picked up afterwards
               if (sleep_d && !SLEEP) begin
                  dly   <= 21'h00_0000;
                  state <= ST_WARM;
               end else if (internal_freq_select != FREQ_SEL) begin
                  tgt_code <= internal_freq_select;
                  tgt_src  <= want_src;
                  dly      <= 21'h00_0000;
                  if (want_src == SOURCE)
                     state <= ST_FALL;
                  else
                     state <= ST_START;
               end
            end
            ST_START: begin
               if (tgt_src == `IFS_SRC_HF)
                  HF_OSC_EN <= 1'b1;
               else if (tgt_src == `IFS_SRC_MF)
                  MF_OSC_EN <= 1'b1;
               else
                  LF_OSC_EN <= 1'b1;
               // Start-up time only counts once the enable is out,
               // so the first cycle of the request is not counted
               if (!new_on)
                  dly <= 21'h00_0000;
               else if (dly >= START_LIM)
                  state <= ST_FALL;
               else
                  dly <= dly + 21'h1;
            end
            ST_FALL: begin
               // Leaving on a falling edge avoids a runt high pulse
               if (old_clk_d && !cur_clk)
                  state <= ST_RISE;
            end
            ST_RISE: begin
               // Output held low here; the new clock takes over on
               // its own rising edge, with enables and status switching on that same edge
               if (!new_clk_d && new_clk) begin
                  SOURCE    <= tgt_src;
                  FREQ_SEL  <= tgt_code;
                  HF_OSC_EN <= (tgt_src == `IFS_SRC_HF);
                  MF_OSC_EN <= (tgt_src == `IFS_SRC_MF);
                  LF_OSC_EN <= (tgt_src == `IFS_SRC_LF);
                  state     <= ST_IDLE;
               end
            end
            ST_WARM: begin
               if (dly >= WARM_LIM)
                  state <= ST_IDLE;
               else
                  dly <= dly + 21'h1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output clock gating: low while asleep, warming or waiting the new rising edge
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         SYS_CLK        <= 1'b0;
         USE_CONFIG_SRC <= 1'b1;
      end else begin
         USE_CONFIG_SRC <= ~use_int & ~cfg_int;
         // The wake cycle itself is still held low, before warm-up starts
         // Hazard: without it one stray pulse leaks out on wake
         if (SLEEP || sleep_d || state == ST_WARM || state == ST_RISE)
            SYS_CLK <= 1'b0;
         else if (~use_int & ~cfg_int)
            SYS_CLK <= ex_c;
         else
            SYS_CLK <= cur_clk;
      end
   end

endmodule

// *** ifs_clock_switch_properties.sv ***
// Port checker for the oscillator select and clock switch block
`timescale 1ns/100ps
`include "ifs_defines.vh"
module ifs_switch_props (
   input wire       CLK,
   input wire       RST,
   input wire       WB_CYC_I,
   input wire       WB_STB_I,
   input wire       WB_ACK_O,
   input wire [31:0] WB_DAT_O,
   input wire       SLEEP,
   input wire       HF_OSC_EN,
   input wire       MF_OSC_EN,
   input wire       LF_OSC_EN,
   input wire       PLL_ACTIVE,
   input wire [3:0] FREQ_SEL,
   input wire [1:0] SOURCE,
   input wire       USE_CONFIG_SRC,
   input wire       SYS_CLK
);
   // Oscillator that feeds each frequency code
   function automatic logic [1:0] src_of(input logic [3:0] c);
      if (c[3] || c == 4'h3) return `IFS_SRC_HF;
      if (c[3:1] == 3'b000) return `IFS_SRC_LF;
      return `IFS_SRC_MF;
   endfunction
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
   ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
   dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000) else $error("read data outside ack");
   source_map_a: assert property (SOURCE == src_of(FREQ_SEL)) else $error("source wrong for code");
   pll_path_a: assert property (PLL_ACTIVE |-> $past(FREQ_SEL) >= 4'hE && !USE_CONFIG_SRC)
      else $error("pll active off its path");
   osc_enable_a: assert property ((SOURCE == `IFS_SRC_HF |-> HF_OSC_EN) and (SOURCE == `IFS_SRC_MF |-> MF_OSC_EN)
      and (SOURCE == `IFS_SRC_LF |-> LF_OSC_EN)) else $error("active oscillator not enabled");
   wake_low_a: assert property ($fell(SLEEP) |=> (!SYS_CLK) [*8]) else $error("clock during warm-up");
endmodule

// *** ifs_tb.sv ***
// Self-checking bench for the oscillator select and clock switch block
`timescale 1ns/100ps
`include "ifs_defines.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge CLK); n++; end end
module tb;
   logic CLK = 0, RST = 1, cyc = 0, stb = 0, we = 0, slp = 0, cfg_pll = 0;
   logic [7:0]  adr = 8'h00, cnt = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, rd, q;
   logic [1:0]  cfg_sel = 2'h0;
   wire         ack, pll, ucs, sys;
   wire [2:0]   oen;
   wire [3:0]   fsel;
   wire [1:0]   src;
   int fails = 0, tests_run = 0, n;
   always #4 CLK = ~CLK;
   // Slow oscillator pins, all well under half the bus clock
   always @(posedge CLK) cnt <= cnt + 8'h01;
   ifs_clock_switch #(.LOCK_CYC(20)) ifs_clock_switch_inst (.CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(q), .WB_ACK_O(ack),
      .CFG_OSC_SEL(cfg_sel), .CFG_PLL_ENABLE(cfg_pll), .SLEEP(slp), .HF_OSC_CLK(cnt[1]), .MF_OSC_CLK(cnt[2]),
      .LF_OSC_CLK(cnt[3]), .EXT_CLK(cnt[1]), .HF_OSC_EN(oen[2]), .MF_OSC_EN(oen[1]), .LF_OSC_EN(oen[0]),
      .PLL_ACTIVE(pll), .FREQ_SEL(fsel), .SOURCE(src), .USE_CONFIG_SRC(ucs), .SYS_CLK(sys));
   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge CLK);
      cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hF; dat <= {24'h00_0000, d};
      k = 0;
      do begin @(posedge CLK); k++; end while (ack !== 1'b1 && k < 100);
      if (ack !== 1'b1) fails++;
      rd = q;
      cyc <= 0; stb <= 0; we <= 0;
   endtask
   task t_reset;
      wb(0, `IFS_ADDR_CTRL, 8'h00); `CHK("ctrl reset", 8'h38, rd[7:0])
      wb(0, `IFS_ADDR_STAT, 8'h00); `CHK("stat reset", 8'h04, rd[7:0] & 8'h76)
      wb(1, `IFS_ADDR_STAT, 8'hFF); wb(1, 8'h08, 8'hFF); wb(0, 8'h08, 8'h00);
      `CHK("unmapped", 32'h0000_0000, rd)
      wb(0, `IFS_ADDR_STAT, 8'h00); `CHK("stat ro", 8'h04, rd[7:0] & 8'h76)
   endtask
   // Every frequency code, timing the switch against start-up
   task t_codes;
      static logic [3:0] cd [16] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h3, 4'h7, 4'h6, 4'h5, 4'h4,
                              4'h2, 4'h1, 4'h0};
      static logic [1:0] sr [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 2};
      logic [1:0] pv;
      logic [7:0] bt;
      pv = 2'h1;
      for (int i = 0; i < 16; i++) begin
         wb(1, `IFS_ADDR_CTRL, {1'b0, cd[i], 3'b010});
         `WAITC(fsel === cd[i])
         `CHK("fsel", cd[i], fsel)
         `CHK("source", sr[i], src)
         `CHK("osc en", 3'b100 >> sr[i], oen)
         `CHK("startup", pv != sr[i], n >= `IFS_STARTUP_CYC)
         `CHK("no pll", 1'b0, pll)
         wb(0, `IFS_ADDR_CTRL, 8'h00); `CHK("ctrl", {1'b0, cd[i], 3'b010}, rd[7:0])
         bt = (sr[i] == 0) ? 8'h10 : (sr[i] == 1) ? 8'h04 : 8'h02;
         wb(0, `IFS_ADDR_STAT, 8'h00); `CHK("osc on", bt, rd[7:0] & 8'h16)
         pv = sr[i];
      end
   endtask
   task t_pll;
      wb(1, `IFS_ADDR_CTRL, 8'hF8); `WAITC(pll === 1'b1)
      `CHK("pll on", 1'b1, pll)
      wb(0, `IFS_ADDR_STAT, 8'h00); `CHK("pll ready", 1'b1, rd[6])
      wb(1, `IFS_ADDR_CTRL, 8'h78); `WAITC(pll === 1'b0)
      `CHK("pll off", 1'b0, pll)
      cfg_pll <= 1; `WAITC(pll === 1'b1)
      `CHK("cfg pll", 1'b1, pll)
      wb(1, `IFS_ADDR_CTRL, 8'h7A); `WAITC(pll === 1'b0)
      `CHK("scs1x pll", 1'b0, pll)
      cfg_pll <= 0; wb(1, `IFS_ADDR_CTRL, 8'hE8); repeat (600) @(posedge CLK);
      `CHK("4MHz pll", 1'b0, pll)
      cfg_sel <= 2'h1; wb(1, `IFS_ADDR_CTRL, 8'h68); repeat (4) @(posedge CLK);
      `CHK("cfg src", 1'b1, ucs)
      wb(1, `IFS_ADDR_CTRL, 8'h69); repeat (4) @(posedge CLK);
      `CHK("reserved", 1'b0, ucs)
   endtask
   task t_sleep;
      wb(0, `IFS_ADDR_STAT, 8'h00); `CHK("switch done", 1'b1, rd[4])
      slp <= 1; repeat (20) @(posedge CLK);
      slp <= 0; repeat (2) @(posedge CLK);
      `CHK("warm", 1'b0, sys)
      `WAITC(sys === 1'b1)
      `CHK("warm len", 1'b1, n >= `IFS_WARM_CYC)
      `CHK("clk back", 1'b1, sys)
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #(8 * 90000);
      fails++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge CLK);
      RST <= 0;
      t_reset; t_codes; t_pll; t_sleep;
      wrap_up;
   end
endmodule
bind ifs_clock_switch ifs_switch_props ifs_switch_props_inst (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .SLEEP(SLEEP), .HF_OSC_EN(HF_OSC_EN),
   .MF_OSC_EN(MF_OSC_EN), .LF_OSC_EN(LF_OSC_EN), .PLL_ACTIVE(PLL_ACTIVE), .FREQ_SEL(FREQ_SEL),
   .SOURCE(SOURCE), .USE_CONFIG_SRC(USE_CONFIG_SRC), .SYS_CLK(SYS_CLK));
